// *** logic/cpu_regs_pkg.sv ***
// Constants, types and helpers for the programmer-visible register set.
// Assumes one core clock, an APB slave port and an execution unit driving ops.
package cpu_regs_pkg;
    localparam int XLEN       = 32;
    localparam int EXT_ADDR_W = 24;
    localparam int EXT_DATA_W = 16;
    localparam int NUM_PHYS   = 17;
    localparam int RIDX_W     = 5;
    localparam logic [RIDX_W-1:0] USP_IDX = 5'h0f;
    localparam logic [RIDX_W-1:0] SSP_IDX = 5'h10;
    localparam logic [3:0] STACK_SEL = 4'hf;

    // Status word field positions
    localparam int SW_C     = 0;
    localparam int SW_V     = 1;
    localparam int SW_Z     = 2;
    localparam int SW_N     = 3;
    localparam int SW_X     = 4;
    localparam int SW_MASK  = 8;
    localparam int SW_PRIV  = 13;
    localparam int SW_TRACE = 15;
    localparam logic [15:0] SW_IMPL  = 16'ha71f;
    localparam logic [15:0] SW_RESET = 16'h2700;

    // APB map, byte addresses
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] APB_SSP = 8'h40;
    localparam logic [APB_AW-1:0] APB_PC  = 8'h44;
    localparam logic [APB_AW-1:0] APB_SW  = 8'h48;

    typedef enum logic [2:0] {SZ_BIT, SZ_DIGIT, SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EA} op_kind_t;
    typedef enum logic [3:0] {
        EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX,
        EA_ABS_W, EA_ABS_L, EA_PC_DISP, EA_PC_INDEX, EA_IMM, EA_QUICK, EA_IMPLIED
    } ea_mode_t;

    // Byte step of a pointer update
    function automatic logic [XLEN-1:0] size_bytes(input size_t sz);
        size_bytes = (sz == SZ_LONG) ? 32'h0000_0004 :
                     (sz == SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction

    function automatic logic [XLEN-1:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    function automatic logic [XLEN-1:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction
endpackage

// *** logic/cpu_reg_mem.sv ***
// Storage for the general registers and both stack pointers.
// Assumes one writer per cycle; read data appear one clock after the address.
module cpu_reg_mem #(
    parameter int DEPTH = 17,
    parameter int WIDTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
        $error("cpu_reg_mem: DEPTH does not fit AW");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Cleared at reset so no register reads as unknown
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (we && int'(waddr) < DEPTH) begin
            mem_reg[waddr] <= wdata;
        end
    end

    // Registered read, write-before-read not forwarded
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= (int'(raddr) < DEPTH) ? mem_reg[raddr] : '0;
        end
    end
endmodule

// *** logic/cpu_ea_calc.sv ***
// Operand address generator, purely combinational.
// Assumes base, index and extension words are already fetched by the caller.
module cpu_ea_calc
    import cpu_regs_pkg::*;
(
    input  wire ea_mode_t        mode,
    input  wire size_t           size,
    input  wire logic [XLEN-1:0] base,
    input  wire logic [XLEN-1:0] index,
    input  wire logic            index_long,
    input  wire logic [XLEN-1:0] pc,
    input  wire logic [XLEN-1:0] ext,
    output logic      [XLEN-1:0] addr,
    output logic      [XLEN-1:0] base_next,
    output logic                 base_wb
);
    logic [XLEN-1:0] idx_val;
    logic [XLEN-1:0] step;
    logic [XLEN-1:0] quick;

    // Word index is sign-extended, any general register may be the index
    assign idx_val = index_long ? index : sext16(index[15:0]);
    assign step    = size_bytes(size);
    assign quick   = (ext[2:0] == 3'h0) ? 32'h0000_0008 : {29'h0, ext[2:0]};

    // Pointer adjustment only for the two stepping forms
    assign base_wb   = (mode == EA_POSTINC) || (mode == EA_PREDEC);
    assign base_next = (mode == EA_PREDEC) ? base - step : base + step;

    // Fourteen modes in six groups
    always_comb begin
        unique case (mode)
            EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_IMPLIED: addr = base;
            EA_PREDEC:   addr = base - step;
            EA_DISP:     addr = base + sext16(ext[15:0]);
            EA_INDEX:    addr = base + sext8(ext[7:0]) + idx_val;
            EA_ABS_W:    addr = sext16(ext[15:0]);
            EA_ABS_L:    addr = ext;
            EA_PC_DISP:  addr = pc + sext16(ext[15:0]);
            EA_PC_INDEX: addr = pc + sext8(ext[7:0]) + idx_val;
            EA_IMM:      addr = ext;
            EA_QUICK:    addr = quick;
            default:     addr = base;
        endcase
    end
endmodule

// *** logic/cpu_regs.sv ***
// Programmer register set: general registers, stack pointers, PC, status word.
// Assumes an execution unit with a valid/ready op port and an APB master.
module cpu_regs
    import cpu_regs_pkg::*;
#(
    parameter int EXT_AW = EXT_ADDR_W,
    parameter int EXT_DW = EXT_DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              op_valid,
    input  wire op_kind_t          op_kind,
    input  wire logic [3:0]        op_reg,
    input  wire size_t             op_size,
    input  wire logic [XLEN-1:0]   op_wdata,
    input  wire ea_mode_t          op_mode,
    input  wire logic [3:0]        op_index,
    input  wire logic              op_index_long,
    input  wire logic [XLEN-1:0]   op_ext,
    input  wire logic              pc_we,
    input  wire logic [XLEN-1:0]   pc_in,
    input  wire logic              flags_we,
    input  wire logic [3:0]        flags_in,
    input  wire logic              x_we,
    input  wire logic              x_in,
    input  wire logic              sw_we,
    input  wire logic [15:0]       sw_in,
    output logic                   op_ready,
    output logic                   res_valid,
    output logic [XLEN-1:0]        res_data,
    output logic [EXT_AW-1:0]      ext_addr,
    output logic [EXT_DW-1:0]      ext_data,
    output logic [XLEN-1:0]        program_counter,
    output logic [15:0]            status_word,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [XLEN-1:0]   pwdata,
    output logic                   pready,
    output logic [XLEN-1:0]        prdata,
    output logic                   pslverr
);
    // Outside paths must be no wider than the inner word
    if (EXT_AW < 1 || EXT_AW > XLEN || EXT_DW < 1 || EXT_DW > XLEN) begin : g_chk
        $error("cpu_regs: external widths must lie in 1..32");
    end

    typedef enum logic [1:0] {S_IDLE, S_BASE, S_INDEX, S_APB} state_t;

    // A7 means the stack pointer of the current privilege state
    function automatic logic [RIDX_W-1:0] phys_idx(input logic [3:0] r, input logic priv);
        phys_idx = (r != STACK_SEL) ? {1'b0, r} : (priv ? SSP_IDX : USP_IDX);
    endfunction

    // Size-aware write; address registers take whole words sign-extended
    function automatic logic [XLEN-1:0] merge(input logic [XLEN-1:0] old_v,
                                              input logic [XLEN-1:0] new_v,
                                              input size_t sz, input logic is_addr,
                                              input logic [4:0] bitno);
        logic [XLEN-1:0] bit_v;
        bit_v = old_v;
        bit_v[bitno] = new_v[0];
        if (is_addr) begin
            merge = (sz == SZ_LONG) ? new_v : sext16(new_v[15:0]);
        end else begin
            unique case (sz)
                SZ_BIT:   merge = bit_v;
                SZ_DIGIT: merge = {old_v[31:4], new_v[3:0]};
                SZ_BYTE:  merge = {old_v[31:8], new_v[7:0]};
                SZ_WORD:  merge = {old_v[31:16], new_v[15:0]};
                default:  merge = new_v;
            endcase
        end
    endfunction

    // Size-aware read, zero-extended into the result
    function automatic logic [XLEN-1:0] extract(input logic [XLEN-1:0] v, input size_t sz,
                                                input logic [4:0] bitno);
        unique case (sz)
            SZ_BIT:   extract = {31'h0, v[bitno]};
            SZ_DIGIT: extract = {28'h0, v[3:0]};
            SZ_BYTE:  extract = {24'h0, v[7:0]};
            SZ_WORD:  extract = {16'h0, v[15:0]};
            default:  extract = v;
        endcase
    endfunction

    state_t            state_reg;
    state_t            state_next;
    op_kind_t          kind_reg;
    size_t             size_reg;
    ea_mode_t          mode_reg;
    logic [3:0]        sel_reg;
    logic [3:0]        idx_sel_reg;
    logic              idx_long_reg;
    logic [XLEN-1:0]   wdata_reg;
    logic [XLEN-1:0]   ext_reg;
    logic [XLEN-1:0]   base_reg;
    logic [XLEN-1:0]   pc_reg;
    logic [XLEN-1:0]   pc_next;
    logic [15:0]       sw_reg;
    logic [15:0]       sw_next;
    logic              op_ready_reg;
    logic              res_valid_reg;
    logic [XLEN-1:0]   res_data_reg;
    logic [EXT_AW-1:0] ext_addr_reg;
    logic [EXT_DW-1:0] ext_data_reg;
    logic              pready_reg;
    logic [XLEN-1:0]   prdata_reg;
    logic              pslverr_reg;

    wire logic [XLEN-1:0] mem_rdata;
    wire logic [XLEN-1:0] ea_addr;
    wire logic [XLEN-1:0] ea_base_next;
    wire logic            ea_base_wb;

    // Privilege and the named status fields
    wire logic       priv      = sw_reg[SW_PRIV];
    wire logic       trace     = sw_reg[SW_TRACE];
    wire logic [2:0] int_mask  = sw_reg[SW_MASK +: 3];

    // Op handshake and sequencing decode
    wire logic accept_op  = op_ready_reg && op_valid;
    wire logic in_base    = state_reg == S_BASE;
    wire logic in_index   = state_reg == S_INDEX;
    wire logic needs_idx  = (kind_reg == OP_EA) &&
                            ((mode_reg == EA_INDEX) || (mode_reg == EA_PC_INDEX));
    wire logic to_index   = in_base && needs_idx;
    wire logic op_done    = (in_base && !needs_idx) || in_index;
    wire logic sel_is_adr = sel_reg[3];
    wire logic [RIDX_W-1:0] sel_phys = phys_idx(sel_reg, priv);

    // APB decode; exec-side status and PC writes take precedence
    wire logic apb_go     = (state_reg == S_IDLE) && !op_valid && !sw_we && !pc_we &&
                            psel && penable && !pready_reg;
    wire logic apb_gp     = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
    wire logic apb_ssp    = paddr == APB_SSP;
    wire logic apb_pc     = paddr == APB_PC;
    wire logic apb_sw     = paddr == APB_SW;
    wire logic apb_err    = !(apb_gp || apb_ssp || apb_pc || apb_sw) ||
                            (apb_ssp && !priv);
    wire logic apb_mem    = !apb_err && (apb_gp || apb_ssp);
    wire logic apb_mem_rd = apb_go && !pwrite && apb_mem;
    wire logic apb_mem_wr = apb_go && pwrite && apb_mem;
    wire logic [RIDX_W-1:0] apb_idx = apb_ssp ? SSP_IDX : {1'b0, paddr[5:2]};

    // Memory read port: op base on accept, then index, else APB
    wire logic [RIDX_W-1:0] rd_addr = accept_op ? phys_idx(op_reg, priv) :
                                      to_index  ? phys_idx(idx_sel_reg, priv) :
                                      apb_idx;

    // Memory write port: op write, pointer step or APB, never two at once
    wire logic [XLEN-1:0] op_merged = merge(mem_rdata, wdata_reg, size_reg, sel_is_adr,
                                            ext_reg[4:0]);
    wire logic w_op  = in_base && (kind_reg == OP_WRITE);
    wire logic w_ea  = in_base && (kind_reg == OP_EA) && ea_base_wb;
    wire logic mem_we = w_op || w_ea || apb_mem_wr;
    wire logic [RIDX_W-1:0] wr_addr = apb_mem_wr ? apb_idx : sel_phys;
    wire logic [XLEN-1:0]   wr_data = apb_mem_wr ? pwdata :
                                      w_op ? op_merged : ea_base_next;

    // Result of a finished op
    wire logic [XLEN-1:0] result = (kind_reg == OP_READ)  ? extract(mem_rdata, size_reg,
                                                                    ext_reg[4:0]) :
                                   (kind_reg == OP_WRITE) ? op_merged : ea_addr;

    // Status word: unprivileged writers reach only the flag byte
    wire logic        apb_sw_wr = apb_go && pwrite && apb_sw;
    wire logic [15:0] sw_wval   = sw_we ? sw_in : pwdata[15:0];
    wire logic [15:0] sw_masked = priv ? (sw_wval & SW_IMPL) :
                                  {sw_reg[15:8], sw_wval[7:0] & SW_IMPL[7:0]};
    wire logic [15:0] sw_base   = (sw_we || apb_sw_wr) ? sw_masked : sw_reg;
    // Extend bit moves only on its own strobe or a status word write, so it stays sticky across flag updates
    assign sw_next = {sw_base[15:5],
                      x_we ? x_in : sw_base[SW_X],
                      flags_we ? flags_in : sw_base[SW_N:SW_C]};
    assign pc_next = pc_we ? pc_in : ((apb_go && pwrite && apb_pc) ? pwdata : pc_reg);

    assign state_next = accept_op  ? S_BASE  :
                        to_index   ? S_INDEX :
                        apb_mem_rd ? S_APB   : S_IDLE;

    cpu_reg_mem #(
        .DEPTH (NUM_PHYS),
        .WIDTH (XLEN),
        .AW    (RIDX_W)
    ) u_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .we       (mem_we),
        .waddr    (wr_addr),
        .wdata    (wr_data),
        .raddr    (rd_addr),
        .rdata    (mem_rdata)
    );

    cpu_ea_calc u_ea (
        .mode       (mode_reg),
        .size       (size_reg),
        .base       (in_index ? base_reg : mem_rdata),
        .index      (mem_rdata),
        .index_long (idx_long_reg),
        .pc         (pc_reg),
        .ext        (ext_reg),
        .addr       (ea_addr),
        .base_next  (ea_base_next),
        .base_wb    (ea_base_wb)
    );

    // Sequencer and latched op fields
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= S_IDLE;
            op_ready_reg <= 1'b0;
            kind_reg     <= OP_READ;
            size_reg     <= SZ_LONG;
            mode_reg     <= EA_DREG;
            sel_reg      <= 4'h0;
            idx_sel_reg  <= 4'h0;
            idx_long_reg <= 1'b0;
            wdata_reg    <= '0;
            ext_reg      <= '0;
            base_reg     <= '0;
        end else begin
            state_reg    <= state_next;
            op_ready_reg <= state_next == S_IDLE;
            if (accept_op) begin
                kind_reg     <= op_kind;
                size_reg     <= op_size;
                mode_reg     <= op_mode;
                sel_reg      <= op_reg;
                idx_sel_reg  <= op_index;
                idx_long_reg <= op_index_long;
                wdata_reg    <= op_wdata;
                ext_reg      <= op_ext;
            end
            if (to_index) begin
                base_reg <= mem_rdata;
            end
        end
    end

    // Op results; outside paths carry only the low address and data bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_valid_reg <= 1'b0;
            res_data_reg  <= '0;
            ext_addr_reg  <= '0;
            ext_data_reg  <= '0;
        end else begin
            res_valid_reg <= op_done;
            if (op_done) begin
                res_data_reg <= result;
                ext_data_reg <= result[EXT_DW-1:0];
                if (kind_reg == OP_EA) begin
                    ext_addr_reg <= ea_addr[EXT_AW-1:0];
                end
            end
        end
    end

    // Program counter and status word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc_reg <= '0;
            sw_reg <= SW_RESET;
        end else begin
            pc_reg <= pc_next;
            sw_reg <= sw_next;
        end
    end

    // APB answer; ready is a one-cycle pulse that blocks a new start while high, so no access repeats in its ready cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= (apb_go && !apb_mem_rd) || (state_reg == S_APB);
            pslverr_reg <= apb_go && apb_err;
            if (state_reg == S_APB) begin
                prdata_reg <= mem_rdata;
            end else if (apb_go) begin
                prdata_reg <= (pwrite || apb_err) ? '0 :
                              apb_pc ? pc_reg : {16'h0, sw_reg};
            end
        end
    end

    assign op_ready        = op_ready_reg;
    assign res_valid       = res_valid_reg;
    assign res_data        = res_data_reg;
    assign ext_addr        = ext_addr_reg;
    assign ext_data        = ext_data_reg;
    assign program_counter = pc_reg;
    assign status_word     = sw_reg;
    assign pready          = pready_reg;
    assign prdata          = prdata_reg;
    assign pslverr         = pslverr_reg;

    // Trace and mask are visible only through the status word
    wire logic unused_fields = trace ^ (^int_mask);
endmodule

// *** bench/cpu_regs_checker.sv ***
// Checker for the register set: op handshake, status word, PC and APB errors.
// Assumes it is bound into cpu_regs and sees that module's ports by name.
module cpu_regs_checker
    import cpu_regs_pkg::*;
#(
    parameter int EXT_AW = EXT_ADDR_W,
    parameter int EXT_DW = EXT_DATA_W
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              op_valid,
    input wire logic              op_ready,
    input wire logic              res_valid,
    input wire op_kind_t          op_kind,
    input wire ea_mode_t          op_mode,
    input wire logic [XLEN-1:0]   op_ext,
    input wire logic [XLEN-1:0]   res_data,
    input wire logic [EXT_AW-1:0] ext_addr,
    input wire logic [EXT_DW-1:0] ext_data,
    input wire logic              pc_we,
    input wire logic [XLEN-1:0]   pc_in,
    input wire logic              flags_we,
    input wire logic [3:0]        flags_in,
    input wire logic              x_we,
    input wire logic              x_in,
    input wire logic              sw_we,
    input wire logic [15:0]       sw_in,
    input wire logic [15:0]       status_word,
    input wire logic [XLEN-1:0]   program_counter,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [XLEN-1:0]   prdata
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Op accepted at this edge
    logic take;
    assign take = op_valid && op_ready;

    // Short absolute address must come back sign-extended on the outside path
    property abs_short_p;
        logic [15:0] e;
        (take && op_kind == OP_EA && op_mode == EA_ABS_W, e = op_ext[15:0])
            |-> ##2 ext_addr == EXT_AW'({{16{e[15]}}, e});
    endproperty

    take_busy_a: assert property (take |=> !op_ready && !res_valid)
        else $error("op port not busy after take");
    res_time_a: assert property (take && op_kind != OP_EA |-> ##2 res_valid)
        else $error("op result missing two edges after take");
    ext_data_a: assert property (res_valid |-> ext_data == res_data[EXT_DW-1:0])
        else $error("outside data path differs from result");
    abs_short_a: assert property (abs_short_p)
        else $error("short absolute address wrong");
    user_upper_a: assert property (sw_we && !status_word[SW_PRIV]
        |=> status_word[15:8] == $past(status_word[15:8])) else $error("upper status changed");
    priv_write_a: assert property (sw_we && status_word[SW_PRIV] && !flags_we && !x_we
        |=> status_word == ($past(sw_in) & SW_IMPL)) else $error("status write lost");
    flags_load_a: assert property (flags_we |=> status_word[3:0] == $past(flags_in))
        else $error("condition flags not loaded");
    extend_load_a: assert property (x_we |=> status_word[SW_X] == $past(x_in))
        else $error("extend flag not loaded");
    pc_load_a: assert property (pc_we |=> program_counter == $past(pc_in))
        else $error("program counter not loaded");
    apb_error_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused access returned data");

    // Main scenarios reached
    cover property (take && op_mode == EA_INDEX);
    cover property (pready && pslverr);
    cover property (sw_we && !status_word[SW_PRIV]);
endmodule

// *** bench/exec_unit_model.sv ***
// Execution unit stand-in issuing register operations on the op port.
// Assumes reset is released before the first call of run_op.
module exec_unit_model
    import cpu_regs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       op_ready,
    input  wire logic       res_valid,
    output logic            op_valid = 1'b0,
    output op_kind_t        op_kind = OP_READ,
    output logic [3:0]      op_reg = 4'h0,
    output size_t           op_size = SZ_LONG,
    output logic [XLEN-1:0] op_wdata = 32'h0,
    output ea_mode_t        op_mode = EA_DREG,
    output logic [3:0]      op_index = 4'h1,
    output logic            op_index_long = 1'b1,
    output logic [XLEN-1:0] op_ext = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;

    // Request held until taken; waits for the result so a read sees settled data
    task automatic run_op(input op_kind_t k, input logic [3:0] r, input size_t sz,
                          input logic [31:0] d, input ea_mode_t m, input logic [31:0] e,
                          input logic [3:0] ix);
        op_valid <= 1'b1;
        op_kind  <= k;
        op_reg   <= r;
        op_size  <= sz;
        op_wdata <= d;
        op_mode  <= m;
        op_ext   <= e;
        op_index <= ix;
        op_index_long <= ix[3];  // Address index long, data index word
        do @(posedge core_clk); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        do @(posedge core_clk); while (res_valid !== 1'b1);
    endtask
endmodule

// *** bench/cpu_programmer_register_model_tb_top.sv ***
// Bench for the register set: ops via the model, APB and status strobes here.
// Assumes a 200 MHz core clock and an active-high asynchronous reset.
module cpu_programmer_register_model_tb_top;
    import cpu_regs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk, op_valid, op_index_long, op_ready, res_valid, pready, pslverr, err;
    logic        rst = 1'b1, pc_we = 1'b0, flags_we = 1'b0, x_we = 1'b0, x_in = 1'b0;
    logic        sw_we = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [3:0]  op_reg, op_index, flags_in = 4'h0;
    logic [15:0] sw_in = 16'h0, status_word, ext_data;
    logic [7:0]  paddr = 8'h00;
    logic [23:0] ext_addr;
    logic [31:0] op_wdata, op_ext, res_data, program_counter, prdata, q, b;
    logic [31:0] pc_in = 32'h0, pwdata = 32'h0;
    op_kind_t    op_kind;
    size_t       op_size;
    ea_mode_t    op_mode;
    size_t       szs[3] = '{SZ_BYTE, SZ_WORD, SZ_LONG};
    int          miscompares = 0, compares = 0, cycles = 0;

    cpu_regs u_dut (.*);
    exec_unit_model u_exec (.*);

    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Cut a hang short well past the expected run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer, then an idle edge so back-to-back calls never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [3:0] r, input size_t sz);
        u_exec.run_op(OP_READ, r, sz, 32'h0, EA_DREG, 32'h0, 4'h1);
    endtask

    task automatic ea(input ea_mode_t m, input logic [31:0] e, input logic [3:0] ix,
                      input logic [31:0] exp);
        u_exec.run_op(OP_EA, 4'h9, SZ_LONG, 32'h0, m, e, ix);
        chk("ext_addr", {8'h0, exp[23:0]}, {8'h0, ext_addr});
    endtask

    task automatic sw_set(input logic [15:0] v);
        sw_we <= 1'b1;
        sw_in <= v;
        @(posedge core_clk);
        sw_we <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: strobes, APB map, operand sizes, address modes, privilege
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("status_word", 32'h2700, {16'h0, status_word});
        pc_we    <= 1'b1;
        pc_in    <= 32'h0000_1000;
        flags_we <= 1'b1;
        flags_in <= 4'ha;
        x_we     <= 1'b1;
        x_in     <= 1'b1;
        @(posedge core_clk);
        pc_we    <= 1'b0;
        flags_we <= 1'b0;
        x_we     <= 1'b0;
        @(posedge core_clk);
        chk("program_counter", 32'h1000, program_counter);
        chk("status_word", 32'h271a, {16'h0, status_word});
        $display("test strobes done");
        apb(1'b1, 8'h0c, 32'hdead_beef);
        apb(1'b0, 8'h0c, 32'h0);
        chk("apb data reg", 32'hdead_beef, q);
        apb(1'b0, APB_PC, 32'h0);
        chk("apb pc", 32'h1000, q);
        apb(1'b0, 8'h80, 32'h0);
        chk("apb unmapped", 32'h1, {31'h0, err});
        $display("test apb done");
        u_exec.run_op(OP_WRITE, 4'h1, SZ_LONG, 32'h1122_3344, EA_DREG, 32'h0, 4'h1);
        u_exec.run_op(OP_WRITE, 4'h1, SZ_BYTE, 32'h0000_00aa, EA_DREG, 32'h0, 4'h1);
        rd(4'h1, SZ_LONG);
        chk("data long", 32'h1122_33aa, res_data);
        rd(4'h1, SZ_WORD);
        chk("data word", 32'h0000_33aa, res_data);
        rd(4'h3, SZ_BYTE);
        chk("data byte", 32'h0000_00ef, res_data);
        u_exec.run_op(OP_WRITE, 4'h2, SZ_BIT, 32'h1, EA_DREG, 32'h1f, 4'h1);
        u_exec.run_op(OP_WRITE, 4'h2, SZ_DIGIT, 32'h5, EA_DREG, 32'h0, 4'h1);
        rd(4'h2, SZ_BIT);
        chk("data bit", 32'h1, res_data);
        rd(4'h2, SZ_LONG);
        chk("data bit digit", 32'h8000_0005, res_data);
        u_exec.run_op(OP_WRITE, 4'h9, SZ_WORD, 32'h0000_8000, EA_DREG, 32'h0, 4'h1);
        rd(4'h9, SZ_LONG);
        chk("addr word", 32'hffff_8000, res_data);
        $display("test sizes done");
        b = 32'hffff_8000;
        foreach (szs[i]) begin
            u_exec.run_op(OP_EA, 4'h9, szs[i], 32'h0, EA_POSTINC, 32'h0, 4'h1);
            b = b + (32'h1 << i);
            rd(4'h9, SZ_LONG);
            chk("postinc", b, res_data);
        end
        b = b - 32'h4;
        ea(EA_PREDEC, 32'h0, 4'h1, b);
        ea(EA_DISP, 32'h0000_fffe, 4'h1, b - 32'h2);
        ea(EA_INDEX, 32'h0000_00f0, 4'h1, b + 32'h33aa - 32'h10);
        ea(EA_ABS_W, 32'h0000_8000, 4'h1, 32'hffff_8000);
        ea(EA_ABS_L, 32'h0012_3456, 4'h1, 32'h0012_3456);
        ea(EA_PC_DISP, 32'h0000_0010, 4'h1, 32'h0000_1010);
        ea(EA_PC_INDEX, 32'h0000_0004, 4'h9, 32'h0000_1004 + b);
        $display("test modes done");
        sw_set(16'h0000);
        chk("status_word", 32'h0000, {16'h0, status_word});
        apb(1'b0, APB_SSP, 32'h0);
        chk("ssp refused", 32'h1, {31'h0, err});
        sw_set(16'ha7ff);
        chk("status_word", 32'h001f, {16'h0, status_word});
        $display("test privilege done");
        close_out();
    end
endmodule

bind cpu_regs cpu_regs_checker #(.EXT_AW(EXT_AW), .EXT_DW(EXT_DW)) u_chk (.*);
